// ### common/sfra_params.svh
`ifndef SFRA_PARAMS_SVH
`define SFRA_PARAMS_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SFRA_READ_STATUS_ONE_CMD     8'h05
`define SFRA_READ_STATUS_TWO_CMD     8'h07
`define SFRA_READ_CONFIG_CMD         8'h35
`define SFRA_BANK_READ_CMD           8'h16
`define SFRA_BANK_WRITE_CMD          8'h17
`define SFRA_LEGACY_BANK_ACCESS_CMD  8'hb9
`define SFRA_REGISTER_WRITE_CMD      8'h01
`define SFRA_WRITE_ENABLE_CMD        8'h06

// ----------------------------------------
// Bit counts on the link
// ----------------------------------------
`define SFRA_CNT_OPCODE_LAST  6'h07
`define SFRA_CNT_BYTE1_LAST   6'h0f
`define SFRA_CNT_BYTE2_LAST   6'h17
`define SFRA_CNT_OPCODE_DONE  6'h08
`define SFRA_CNT_ONE_BYTE     6'h10
`define SFRA_CNT_TWO_BYTES    6'h18
`define SFRA_CNT_MAX          6'h3f

// ----------------------------------------
// Status one, config and bank fields
// ----------------------------------------
`define SFRA_SR1_BUSY   0
`define SFRA_SR1_WEL    1
`define SFRA_SR1_BP_LO  2
`define SFRA_SR1_BP_HI  4
`define SFRA_SR1_EERR   5
`define SFRA_SR1_PERR   6
`define SFRA_SR1_STATUS_WRITE_DISABLE   7
`define SFRA_CR_QUAD    1
`define SFRA_BAR_EXT    7
`define SFRA_SR1_RESET  8'h00
`define SFRA_CR_RESET   8'h00
`define SFRA_BAR_RESET  8'h00

// ----------------------------------------
// Timing and protection
// ----------------------------------------
`define SFRA_CLK_PERIOD_NS   20
`define SFRA_WRITE_TIME_NS   2000
`define SFRA_WRITE_CYCLES \
  ((`SFRA_WRITE_TIME_NS + `SFRA_CLK_PERIOD_NS - 1) / `SFRA_CLK_PERIOD_NS)
`define SFRA_SECTORS   9'h100
`define SFRA_BP_MAX    3'h7

`endif

// ### common/sfra_pkg.sv
package sfra_pkg;

  typedef enum logic [4:0] {
    SFRA_IDLE   = 5'b00001,
    SFRA_OPCODE = 5'b00010,
    SFRA_READ   = 5'b00100,
    SFRA_DATA   = 5'b01000,
    SFRA_SKIP   = 5'b10000
  } sfra_link_state_type;

  typedef enum logic [3:0] {
    SFRA_SEL_SR1  = 4'b0001,
    SFRA_SEL_SR2  = 4'b0010,
    SFRA_SEL_CFG  = 4'b0100,
    SFRA_SEL_BANK = 4'b1000
  } sfra_read_sel_type;

endpackage

// ### testbench/sfra_core_asserts.sv
module sfra_core_chk
  import sfra_pkg::*;
(
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       cs_n,
  input wire logic       wp_n,
  input wire logic       so_oe,
  input wire logic       prog_erase_req,
  input wire logic [7:0] prog_erase_sector,
  input wire logic       prog_erase_accept,
  input wire logic       prog_erase_refused,
  input wire logic [7:0] status_register_one,
  input wire logic [7:0] config_register,
  input wire logic [7:0] bank_register,
  input wire logic [1:0] bank_addr_bits,
  input wire logic       extended_addressing_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // Checks
  // ----------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  logic [7:0] busy_cnt_q;
  logic       prot;
  logic       busy;
  logic [2:0] bp;

  assign busy = status_register_one[0];
  assign bp   = status_register_one[2 +: 3];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_cnt_q <= 8'h00;
    end else if (busy) begin
      busy_cnt_q <= busy_cnt_q + 8'h01;
    end else begin
      busy_cnt_q <= 8'h00;
    end
  end

  // Top 256 >> (7 - bp) sectors locked, none when bp is zero
  always_comb begin
    prot = (bp != 3'h0) &&
           ({1'b0, prog_erase_sector} >= 9'h100 - (9'h100 >> (3'h7 - bp)));
  end

  a_busy_length: assert property (
    $fell(busy) |-> busy_cnt_q >= 8'h63 && busy_cnt_q <= 8'h65)
    else $error("timed write length wrong");
  a_done_clears_wel: assert property (
    $fell(busy) |-> !status_register_one[1])
    else $error("latch not cleared at write end");
  a_write_needs_wel: assert property (
    $rose(busy) |-> $past(status_register_one[1]))
    else $error("write started without latch");
  a_write_after_cs: assert property (
    $rose(busy) |-> cs_n)
    else $error("write started with select low");
  a_hw_protect: assert property (
    $rose(busy) |-> !(status_register_one[7] && !wp_n && !config_register[1]))
    else $error("write accepted while hardware protected");
  a_prot_answer: assert property (
    prog_erase_req |=> prog_erase_refused == $past(prot) &&
                       prog_erase_accept == !$past(prot))
    else $error("wrong protection answer");
  a_no_stray: assert property (
    (prog_erase_accept || prog_erase_refused) |-> $past(prog_erase_req))
    else $error("answer without request");
  a_bank_bits: assert property (
    bank_addr_bits == (bank_register[7] ? 2'h0 : bank_register[1:0]))
    else $error("bank address bits wrong");
  a_ext_bit: assert property (
    extended_addressing_bit == bank_register[7])
    else $error("extended addressing bit wrong");
  a_bank_flags: assert property (
    !$stable(bank_register) |-> $stable(status_register_one[6:5]) &&
                               $stable(busy))
    else $error("bank write touched flags");
  a_oe_idle: assert property (
    cs_n [*8] |-> !so_oe)
    else $error("output driven while deselected");

  c_write: cover property ($fell(busy));
  c_refused: cover property (prog_erase_refused);
  c_read: cover property ($rose(so_oe));
  c_bank: cover property (!$stable(bank_register));
endmodule

bind sfra_core sfra_core_chk u_chk (
  .clock, .rstn, .cs_n, .wp_n, .so_oe, .prog_erase_req, .prog_erase_sector,
  .prog_erase_accept, .prog_erase_refused, .status_register_one,
  .config_register, .bank_register, .bank_addr_bits, .extended_addressing_bit
);

// ### testbench/sfra_host_model.sv
module sfra_host_model (
  input  wire logic clock,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // Mode 0 framing
  // ----------------
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // Clock idles low between frames
  task automatic frame(input logic [7:0] op, input int nd,
                       input logic [15:0] dat, output logic [15:0] rd);
    logic [23:0] bits;
    bits = {op, dat};
    rd = 16'h0000;
    @(negedge clock);
    cs_n = 1'b0;
    for (int i = 0; i < 8 + nd; i++) begin
      si = bits[23 - i];
      repeat (4) @(negedge clock);
      sck = 1'b1;
      if (i >= 8) begin
        rd = {rd[14:0], so};
      end
      repeat (4) @(negedge clock);
      sck = 1'b0;
    end
    repeat (4) @(negedge clock);
    cs_n = 1'b1;
    si = ~si;
    repeat (8) @(negedge clock);
  endtask
endmodule

// ### testbench/spi_flash_register_access_tb_top.sv
module spi_flash_register_access_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // Bench
  // ----------------
  `define CHECK_EQ(got, exp) \
    begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
        num_errors++; \
        $display("ERROR %0t: got %h expected %h", $time, got, exp); \
      end \
    end

  logic        clock, rstn, cs_n, sck, si, wp_n, so, write_fail;
  logic        pe_req, acc, rfs, ext, oe;
  logic [1:0]  bab;
  logic [7:0]  st2, sec, sr1, cr, bank;
  logic [15:0] rd;
  int          num_errors, cmp_count;

  sfra_core DUT (
    .clock, .rstn, .cs_n, .sck, .si, .wp_n, .so, .so_oe(oe), .write_fail,
    .status_two(st2), .prog_erase_req(pe_req), .prog_erase_sector(sec),
    .prog_erase_accept(acc), .prog_erase_refused(rfs),
    .status_register_one(sr1), .config_register(cr), .bank_register(bank),
    .bank_addr_bits(bab), .extended_addressing_bit(ext)
  );

  sfra_host_model HOST (.clock, .cs_n, .sck, .si, .so);

  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic send(input logic [7:0] op, input int nd,
                      input logic [15:0] dat);
    HOST.frame(op, nd, dat, rd);
  endtask

  // Bounded wait for the timed write
  task automatic wait_done();
    int n;
    n = 0;
    while (sr1[0] !== 1'b0 && n < 300) begin
      @(negedge clock);
      n++;
    end
    if (n >= 300) begin
      num_errors++;
      $display("ERROR %0t: busy stuck", $time);
      finish_test();
    end
  endtask

  task automatic reg_write(input int nd, input logic [15:0] dat);
    send(8'h06, 0, 16'h0000);
    send(8'h01, nd, dat);
    wait_done();
  endtask

  task automatic pe_check(input logic [7:0] s, input logic exp_ref);
    @(negedge clock);
    sec = s;
    pe_req = 1'b1;
    @(negedge clock);
    pe_req = 1'b0;
    `CHECK_EQ({acc, rfs}, {~exp_ref, exp_ref})
  endtask

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    num_errors = 0;
    cmp_count = 0;
    rstn = 1'b0;
    wp_n = 1'b1;
    write_fail = 1'b0;
    pe_req = 1'b0;
    sec = 8'h00;
    st2 = 8'h4c;
    repeat (6) @(negedge clock);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    `CHECK_EQ({sr1, cr, bank}, 24'h000000)
    fork
      send(8'h07, 16, 16'h0000);
      begin
        repeat (100) @(negedge clock);
        st2 = 8'h31;
      end
    join
    `CHECK_EQ(rd, 16'h4c31)
    send(8'h01, 8, 16'h1c00);
    `CHECK_EQ(sr1, 8'h00)
    send(8'h06, 0, 16'h0000);
    `CHECK_EQ(sr1, 8'h02)
    wp_n = 1'b0;
    send(8'h01, 8, 16'h0c00);
    send(8'h05, 16, 16'h0000);
    `CHECK_EQ(rd[15:8], 8'h03)
    `CHECK_EQ(rd[7:0], 8'h0c)
    wait_done();
    `CHECK_EQ(sr1, 8'h0c)
    wp_n = 1'b1;
    pe_check(8'hef, 1'b0);
    pe_check(8'hf0, 1'b1);
    pe_check(8'hff, 1'b1);
    pe_check(8'h00, 1'b0);
    send(8'h06, 0, 16'h0000);
    send(8'h01, 12, 16'h8c00);
    `CHECK_EQ(sr1, 8'h0e)
    send(8'h01, 16, 16'h8c00);
    wait_done();
    `CHECK_EQ({sr1, cr}, 16'h8c00)
    wp_n = 1'b0;
    reg_write(8, 16'h0000);
    `CHECK_EQ(sr1, 8'h8e)
    wp_n = 1'b1;
    send(8'h01, 16, 16'h0002);
    wait_done();
    `CHECK_EQ({sr1, cr}, 16'h0002)
    send(8'h35, 16, 16'h0000);
    `CHECK_EQ(rd, 16'h0202)
    `CHECK_EQ(oe, 1'b0)
    reg_write(16, 16'h8002);
    wp_n = 1'b0;
    reg_write(16, 16'h0002);
    `CHECK_EQ(sr1, 8'h00)
    wp_n = 1'b1;
    send(8'h17, 8, 16'h0100);
    `CHECK_EQ({bank, ext, bab}, {8'h01, 1'b0, 2'h1})
    `CHECK_EQ(sr1, 8'h00)
    send(8'h17, 8, 16'h8100);
    send(8'h16, 16, 16'h0000);
    `CHECK_EQ(rd, 16'h8181)
    `CHECK_EQ({ext, bab}, 3'b100)
    send(8'hb9, 0, 16'h0000);
    send(8'h01, 16, 16'hfeff);
    `CHECK_EQ(bank, 8'h82)
    `CHECK_EQ(sr1, 8'h00)
    send(8'hb9, 0, 16'h0000);
    send(8'h05, 8, 16'h0000);
    send(8'h01, 8, 16'h0300);
    `CHECK_EQ({bank, sr1}, 16'h8200)
    write_fail = 1'b1;
    reg_write(16, 16'h0002);
    write_fail = 1'b0;
    `CHECK_EQ(sr1[6], 1'b1)
    finish_test();
  end
endmodule

// ### verilog/sfra_core.sv
`include "sfra_params.svh"
// Function
// - Opcode 05h streams status one, reloaded fresh every eight clocks.
// - Opcode 07h streams status two, reloaded fresh every eight clocks.
// - Opcode 35h streams config register, readable even while busy.
// - Opcode 16h streams the bank register every eight clocks.
// - Opcode 17h plus one byte loads bank register, no write enable.
// - Bank bits feed upper address while extended-addressing bit is zero.
// - Bank write leaves error flags and busy flag untouched.
// - After B9h, register write loads only bank bits 1:0, no enable.
// - Redirected write closes bank access, keeps extended-addressing bit.
// - Any other command or select cycle after B9h closes bank access.
// - Register write 01h needs the write-enable latch set first.
// - Select must rise after 8 or 16 data bits, else write dropped.
// - Select rise starts timed update; busy set, then busy and latch clear.
// - A failed register write sets the program-error flag.
// - Write disable clear: enabled write succeeds whatever protect pin.
// - Write disable set and protect pin low rejects register writes.
// - Block-protect bits refuse program and erase in the top region.
// - Quad bit set turns off hardware register protection.
// - Opcode 06h sets the write-enable latch, status one bit one.
module sfra_core
  import sfra_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  input  wire logic       wp_n,
  output logic            so,
  output logic            so_oe,
  input  wire logic [7:0] status_two,
  input  wire logic       write_fail,
  input  wire logic       prog_erase_req,
  input  wire logic [7:0] prog_erase_sector,
  output logic            prog_erase_accept,
  output logic            prog_erase_refused,
  output logic [7:0]      status_register_one,
  output logic [7:0]      config_register,
  output logic [7:0]      bank_register,
  output logic [1:0]      bank_addr_bits,
  output logic            extended_addressing_bit
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       sck_prev_q;
  logic       cs_prev_q;

  // Bit order: cs_n, sck, si, wp_n
  // Clock bit resets low, its idle level, so no false edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 4'hb;
      sync2_q <= 4'hb;
    end else begin
      sync1_q <= {cs_n, sck, si, wp_n};
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_prev_q <= sync2_q[2];
      cs_prev_q  <= sync2_q[3];
    end
  end

  logic cs_hi;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic si_s;
  logic wp_n_s;
  assign cs_hi    = sync2_q[3];
  assign si_s     = sync2_q[1];
  assign wp_n_s   = sync2_q[0];
  assign sck_rise = !cs_hi && sync2_q[2] && !sck_prev_q;
  assign sck_fall = !cs_hi && !sync2_q[2] && sck_prev_q;
  assign cs_rise  = cs_hi && !cs_prev_q;

  // ----------------------------------------
  // Registers and helpers
  // ----------------------------------------
  sfra_link_state_type state_q;
  sfra_read_sel_type   sel_q;
  logic [5:0]  bit_cnt_q;
  logic [7:0]  in_sh_q;
  logic [7:0]  opcode_q;
  logic [7:0]  byte1_q;
  logic [7:0]  byte2_q;
  logic [7:0]  out_sh_q;
  logic [2:0]  out_cnt_q;
  logic [7:0]  sr1_q;
  logic [7:0]  cr_q;
  logic [7:0]  bar_q;
  logic        bank_access_q;
  logic        pend_cfg_q;
  logic [7:0]  pend_sr1_q;
  logic [7:0]  pend_cr_q;
  logic [15:0] wr_cnt_q;
  logic [7:0]  in_byte;

  assign in_byte = {in_sh_q[6:0], si_s};

  function automatic logic [7:0] read_value(sfra_read_sel_type s,
                                            logic [7:0] sr1,
                                            logic [7:0] sr2,
                                            logic [7:0] cr,
                                            logic [7:0] bar);
    logic [7:0] v;
    v = 8'h00;
    unique case (s)
      SFRA_SEL_SR1:  v = sr1;
      SFRA_SEL_SR2:  v = sr2;
      SFRA_SEL_CFG:  v = cr;
      SFRA_SEL_BANK: v = bar;
    endcase
    return v;
  endfunction

  function automatic logic sector_protected(logic [2:0] bp,
                                            logic [7:0] sector);
    logic [8:0] lim;
    lim = `SFRA_SECTORS - (`SFRA_SECTORS >> (`SFRA_BP_MAX - bp));
    return (bp != 3'h0) && ({1'b0, sector} >= lim);
  endfunction

  // ----------------------------------------
  // Link state
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= SFRA_IDLE;
      sel_q   <= SFRA_SEL_SR1;
    end else if (cs_hi) begin
      state_q <= SFRA_IDLE;
    end else begin
      unique case (state_q)
        SFRA_IDLE: state_q <= SFRA_OPCODE;
        SFRA_OPCODE: begin
          if (sck_rise && bit_cnt_q == `SFRA_CNT_OPCODE_LAST) begin
            unique case (in_byte)
              `SFRA_READ_STATUS_ONE_CMD: begin
                state_q <= SFRA_READ;
                sel_q   <= SFRA_SEL_SR1;
              end
              `SFRA_READ_STATUS_TWO_CMD: begin
                state_q <= SFRA_READ;
                sel_q   <= SFRA_SEL_SR2;
              end
              `SFRA_READ_CONFIG_CMD: begin
                state_q <= SFRA_READ;
                sel_q   <= SFRA_SEL_CFG;
              end
              `SFRA_BANK_READ_CMD: begin
                state_q <= SFRA_READ;
                sel_q   <= SFRA_SEL_BANK;
              end
              `SFRA_BANK_WRITE_CMD:     state_q <= SFRA_DATA;
              `SFRA_REGISTER_WRITE_CMD: state_q <= SFRA_DATA;
              default:                  state_q <= SFRA_SKIP;
            endcase
          end
        end
        SFRA_READ: state_q <= SFRA_READ;
        SFRA_DATA: state_q <= SFRA_DATA;
        SFRA_SKIP: state_q <= SFRA_SKIP;
      endcase
    end
  end

  // ----------------------------------------
  // Input shifting
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_q <= 6'h00;
      in_sh_q   <= 8'h00;
      opcode_q  <= 8'h00;
      byte1_q   <= 8'h00;
      byte2_q   <= 8'h00;
    end else if (cs_hi) begin
      if (!cs_rise) begin
        bit_cnt_q <= 6'h00;
      end
    end else if (sck_rise) begin
      in_sh_q <= in_byte;
      if (bit_cnt_q != `SFRA_CNT_MAX) begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
      if (bit_cnt_q == `SFRA_CNT_OPCODE_LAST) begin
        opcode_q <= in_byte;
      end
      if (bit_cnt_q == `SFRA_CNT_BYTE1_LAST) begin
        byte1_q <= in_byte;
      end
      if (bit_cnt_q == `SFRA_CNT_BYTE2_LAST) begin
        byte2_q <= in_byte;
      end
    end
  end

  // ----------------------------------------
  // Read output
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      so        <= 1'b0;
      so_oe     <= 1'b0;
      out_sh_q  <= 8'h00;
      out_cnt_q <= 3'h0;
    end else if (state_q != SFRA_READ || cs_hi) begin
      so_oe     <= 1'b0;
      out_cnt_q <= 3'h0;
    end else if (sck_fall) begin
      so_oe     <= 1'b1;
      out_cnt_q <= out_cnt_q + 3'h1;
      // MSB first, fresh value per byte
      if (out_cnt_q == 3'h0) begin
        {so, out_sh_q} <= {read_value(sel_q, sr1_q, status_two, cr_q,
                                      bar_q), 1'b0};
      end else begin
        {so, out_sh_q} <= {out_sh_q, 1'b0};
      end
    end
  end

  // ----------------------------------------
  // Command completion at select rise
  // ----------------------------------------
  logic is_wrr;
  logic wrr_len_ok;
  logic hw_locked;
  logic wrr_start;
  logic wr_done;
  assign is_wrr     = cs_rise && state_q == SFRA_DATA &&
                      opcode_q == `SFRA_REGISTER_WRITE_CMD;
  // exactly 8 or 16 data bits
  assign wrr_len_ok = bit_cnt_q == `SFRA_CNT_ONE_BYTE ||
                      bit_cnt_q == `SFRA_CNT_TWO_BYTES;
  // write disable with pin low locks; quad bit lifts it
  assign hw_locked  = sr1_q[`SFRA_SR1_STATUS_WRITE_DISABLE] && !wp_n_s &&
                      !cr_q[`SFRA_CR_QUAD];
  // latch required; pin ignored while unlocked
  assign wrr_start  = is_wrr && !bank_access_q && wrr_len_ok &&
                      sr1_q[`SFRA_SR1_WEL] && !sr1_q[`SFRA_SR1_BUSY] &&
                      !hw_locked;
  assign wr_done    = sr1_q[`SFRA_SR1_BUSY] && wr_cnt_q == 16'h0000;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bank_access_q <= 1'b0;
    end else if (cs_rise) begin
      bank_access_q <= state_q == SFRA_SKIP &&
                       bit_cnt_q == `SFRA_CNT_OPCODE_DONE &&
                       opcode_q == `SFRA_LEGACY_BANK_ACCESS_CMD;
    end
  end

  // bank register, no latch needed, flags untouched
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bar_q <= `SFRA_BAR_RESET;
    end else if (cs_rise && state_q == SFRA_DATA &&
                 bit_cnt_q >= `SFRA_CNT_ONE_BYTE) begin
      if (opcode_q == `SFRA_BANK_WRITE_CMD) begin
        bar_q <= byte1_q;
      end else if (bank_access_q) begin
        // only low two bits, extended bit kept
        bar_q[1:0] <= byte1_q[1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_cnt_q   <= 16'h0000;
      pend_cfg_q <= 1'b0;
      pend_sr1_q <= `SFRA_SR1_RESET;
      pend_cr_q  <= `SFRA_CR_RESET;
    end else if (wrr_start) begin
      wr_cnt_q   <= 16'(`SFRA_WRITE_CYCLES - 1);
      pend_cfg_q <= bit_cnt_q == `SFRA_CNT_TWO_BYTES;
      pend_sr1_q <= byte1_q;
      pend_cr_q  <= byte2_q;
    end else if (sr1_q[`SFRA_SR1_BUSY] && wr_cnt_q != 16'h0000) begin
      wr_cnt_q <= wr_cnt_q - 16'h0001;
    end
  end

  // Status one: hardware flags and written fields
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sr1_q <= `SFRA_SR1_RESET;
    end else begin
      if (wrr_start) begin
        sr1_q[`SFRA_SR1_BUSY] <= 1'b1;
      end else if (wr_done) begin
        sr1_q[`SFRA_SR1_BUSY] <= 1'b0;
        if (write_fail) begin
          sr1_q[`SFRA_SR1_PERR] <= 1'b1;
        end else begin
          sr1_q[`SFRA_SR1_STATUS_WRITE_DISABLE] <= pend_sr1_q[`SFRA_SR1_STATUS_WRITE_DISABLE];
          sr1_q[`SFRA_SR1_BP_HI:`SFRA_SR1_BP_LO] <=
            pend_sr1_q[`SFRA_SR1_BP_HI:`SFRA_SR1_BP_LO];
        end
      end
      // latch set wins over completion clear
      if (cs_rise && state_q == SFRA_SKIP &&
          bit_cnt_q == `SFRA_CNT_OPCODE_DONE &&
          opcode_q == `SFRA_WRITE_ENABLE_CMD) begin
        sr1_q[`SFRA_SR1_WEL] <= 1'b1;
      end else if (wr_done) begin
        sr1_q[`SFRA_SR1_WEL] <= 1'b0;
      end
    end
  end

  // config only with the two-byte form
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cr_q <= `SFRA_CR_RESET;
    end else if (wr_done && !write_fail && pend_cfg_q) begin
      cr_q <= pend_cr_q;
    end
  end

  // ----------------------------------------
  // Array protection check
  // ----------------------------------------
  // block-protect region refusal
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prog_erase_accept  <= 1'b0;
      prog_erase_refused <= 1'b0;
    end else begin
      prog_erase_accept  <= prog_erase_req &&
        !sector_protected(sr1_q[`SFRA_SR1_BP_HI:`SFRA_SR1_BP_LO],
                          prog_erase_sector);
      prog_erase_refused <= prog_erase_req &&
        sector_protected(sr1_q[`SFRA_SR1_BP_HI:`SFRA_SR1_BP_LO],
                         prog_erase_sector);
    end
  end

  // ----------------------------------------
  // Register views
  // ----------------------------------------
  assign status_register_one     = sr1_q;
  assign config_register         = cr_q;
  assign bank_register           = bar_q;
  assign extended_addressing_bit = bar_q[`SFRA_BAR_EXT];
  // bank bits only without extended addressing
  assign bank_addr_bits = bar_q[`SFRA_BAR_EXT] ? 2'b00 : bar_q[1:0];

endmodule
